/* File: hw/sys_control_regs.v */
`timescale 1ns/1ps
`include "sysctl_defs.vh"
// Function
// RULE_01 - debounce code selects common input filter time
// RULE_02 - ramp steps 10 mV per selected interval
// RULE_03 - default supply apply at slot zero
// RULE_04 - reload from defaults leaving sleep state
// RULE_05 - auto boot or wait for wake event
// RULE_06 - flash on time code selects pulse
// RULE_07 - flash rate code selects flashing period
// RULE_08 - rates one to four need charger present
// RULE_09 - watchdog scale zero disables, else multiplies
// RULE_10 - lock bit blocks writes 0x81 to 0x120
// RULE_11 - feedback three clock out or motor stop
// RULE_12 - feedback two supplies good or keepalive
// RULE_13 - feedback one wake indicator or busy low
// RULE_14 - economy bit arms pulsed mode at reset
// RULE_15 - clock enable locked once monitor asserted
// RULE_16 - fault clock only switches off at reset
// RULE_17 - sleep clock only switches off at sleep
// RULE_18 - wake command, cleared 16 s after active
// RULE_19 - shutdown command cleared entering reset mode
// RULE_20 - watchdog kick bit self clears
// RULE_21 - timed flash on start supply, no charger
// RULE_22 - reserved command bits read zero
// RULE_23 - code changes apply at next event
module sys_control_regs #(
	parameter WAKE_HOLD_CYCLES = 32'd640000000,
	parameter TIMED_FLASH_CYCLES = 32'd400000000
) (
	input wire clk_in,
	input wire nrst_in,
	input wire [8:0] addr_in,
	input wire [7:0] wdata_in,
	input wire wr_in,
	input wire rd_in,
	output reg [7:0] rdata_out,
	output wire locked_wr_out,
	input wire in_reset_mode_in,
	input wire in_sleep_state_in,
	input wire in_active_mode_in,
	input wire enter_slot0_in,
	input wire supply_fault_in,
	input wire monitor_on_in,
	input wire wake_valid_in,
	input wire seq_busy_in,
	input wire ramp_busy_in,
	input wire ramp_active_in,
	input wire timed_flash_enable_in,
	input wire start_supply_in,
	input wire charger_present_input_in,
	input wire power_key_input_in,
	input wire shutdown_request_input_in,
	input wire supplies_good_in,
	input wire wake_event_indicator_in,
	input wire clk32k_in,
	input wire fb2_pin_in,
	input wire fb3_pin_in,
	output reg power_key_out,
	output reg shutdown_request_out,
	output reg ramp_step_out,
	output reg default_supply_apply_out,
	output reg config_reload_out,
	output reg seq_start_out,
	output reg pulsed_lowpower_arm_out,
	output reg clock_only_off_out,
	output reg indicator_out_a_out,
	output reg indicator_out_b_out,
	output reg [2:0] timeout_scale_out,
	output reg [6:0] timeout_mult_out,
	output reg watchdog_kick_out,
	output reg keepalive_out,
	output reg motor_stop_out,
	output reg osc_enable_out,
	output reg wake_request_out,
	output reg shutdown_cmd_out,
	output wire fb1_pin_out,
	output wire fb1_pin_oe_out,
	output wire fb2_pin_out,
	output wire fb2_pin_oe_out,
	output wire fb3_pin_out,
	output wire fb3_pin_oe_out
);
	function [31:0] filter_cycles;
		input [2:0] code;
		case (code)
			3'h0: filter_cycles = 32'h0;
			3'h1: filter_cycles = `MS_CYCLES / 10;
			3'h2: filter_cycles = `MS_CYCLES;
			3'h3: filter_cycles = (`MS_CYCLES * 102) / 10;
			3'h4: filter_cycles = (`MS_CYCLES * 512) / 10;
			3'h5: filter_cycles = `MS_CYCLES * 256;
			3'h6: filter_cycles = `MS_CYCLES * 512;
			default: filter_cycles = `MS_CYCLES * 1024;
		endcase
	endfunction
	reg [7:0] seq_q, flash_q, pin_q, cmd_q;
	reg r1_q, r2_q, prev_reset_q, prev_sleep_q, mon_seen_q, boot_wait_q;
	wire rst_n = r2_q;
	reg [1:0] s_key_q, s_sd_q, s_chg_q, s_ss_q, s_fb2_q, s_fb3_q, s_ck_q;
	reg [1:0] s_good_q, s_wev_q;
	reg [31:0] key_cnt_q, sd_cnt_q, wake_cnt_q;
	reg [31:0] flash_cnt_q, flash_lim_q, tflash_cnt_q;
	wire lock_hit, ramp_hit;
	always @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			r1_q <= 1'b0;
			r2_q <= 1'b0;
		end
		else
		begin
			r1_q <= 1'b1;
			r2_q <= r1_q;
		end
	end
	always @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_key_q <= 2'h3;
			s_sd_q <= 2'h3;
			s_chg_q <= 2'h0;
			s_ss_q <= 2'h0;
			s_fb2_q <= 2'h0;
			s_fb3_q <= 2'h3;
			s_ck_q <= 2'h0;
			s_good_q <= 2'h0;
			s_wev_q <= 2'h0;
		end
		else
		begin
			s_key_q <= {s_key_q[0], power_key_input_in};
			s_sd_q <= {s_sd_q[0], shutdown_request_input_in};
			s_chg_q <= {s_chg_q[0], charger_present_input_in};
			s_ss_q <= {s_ss_q[0], start_supply_in};
			s_fb2_q <= {s_fb2_q[0], fb2_pin_in};
			s_fb3_q <= {s_fb3_q[0], fb3_pin_in};
			s_ck_q <= {s_ck_q[0], clk32k_in};
			s_good_q <= {s_good_q[0], supplies_good_in};
			s_wev_q <= {s_wev_q[0], wake_event_indicator_in};
		end
	end
	// write lock only covers the regulator range, not this bank
	assign lock_hit = pin_q[`BIT_LOCK] && addr_in >= `ADDR_LOCK_LO &&
		addr_in <= `ADDR_LOCK_HI; // [RULE_10]
	assign locked_wr_out = wr_in && lock_hit; // [RULE_10]
	always @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			seq_q <= `RST_SEQ_CFG;
			flash_q <= `RST_FLASH_CFG;
			pin_q <= `RST_PIN_CFG;
			cmd_q <= 8'h00;
			rdata_out <= 8'h00;
			mon_seen_q <= 1'b0;
			wake_cnt_q <= 32'h0;
		end
		else
		begin
			if (monitor_on_in)
				mon_seen_q <= 1'b1;
			if (wr_in && addr_in == `ADDR_SEQ_CFG)
				seq_q <= wdata_in;
			if (wr_in && addr_in == `ADDR_FLASH_CFG)
				flash_q <= wdata_in;
			if (wr_in && addr_in == `ADDR_PIN_CFG)
				pin_q <= {wdata_in[7:3], mon_seen_q ?
					pin_q[`BIT_CLK_EN] : wdata_in[`BIT_CLK_EN],
					wdata_in[1:0]}; // [RULE_15]
			if (in_active_mode_in && wake_cnt_q < WAKE_HOLD_CYCLES)
				wake_cnt_q <= wake_cnt_q + 32'h1;
			else if (!in_active_mode_in)
				wake_cnt_q <= 32'h0;
			// writes of one win over the automatic clears
			if (wr_in && addr_in == `ADDR_CMD && wdata_in[`BIT_WAKE])
				cmd_q[`BIT_WAKE] <= 1'b1; // [RULE_18]
			else if (in_active_mode_in &&
				wake_cnt_q + 32'h1 == WAKE_HOLD_CYCLES)
				cmd_q[`BIT_WAKE] <= 1'b0; // [RULE_18]
			if (wr_in && addr_in == `ADDR_CMD && wdata_in[`BIT_SHUTDOWN])
				cmd_q[`BIT_SHUTDOWN] <= 1'b1; // [RULE_19]
			else if (in_reset_mode_in && !prev_reset_q)
				cmd_q[`BIT_SHUTDOWN] <= 1'b0; // [RULE_19]
			cmd_q[`BIT_KICK] <= wr_in && addr_in == `ADDR_CMD &&
				wdata_in[`BIT_KICK]; // [RULE_20]
			cmd_q[7:3] <= 5'h00; // [RULE_22]
			rdata_out <= 8'h00;
			if (rd_in)
				case (addr_in)
					`ADDR_SEQ_CFG: rdata_out <= seq_q;
					`ADDR_FLASH_CFG: rdata_out <= flash_q;
					`ADDR_PIN_CFG: rdata_out <= pin_q;
					`ADDR_CMD: rdata_out <= cmd_q & `CMD_MASK; // [RULE_22]
					default: rdata_out <= 8'h00;
				endcase
		end
	end
	// filter limit sampled live, so a new code acts on the next edge
	always @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			key_cnt_q <= 32'h0;
			sd_cnt_q <= 32'h0;
			power_key_out <= 1'b1;
			shutdown_request_out <= 1'b1;
		end
		else
		begin
			if (s_key_q[1] == power_key_out)
				key_cnt_q <= 32'h0;
			else if (key_cnt_q >= filter_cycles(seq_q[2:0])) // [RULE_23]
			begin
				power_key_out <= s_key_q[1]; // [RULE_01]
				key_cnt_q <= 32'h0;
			end
			else
				key_cnt_q <= key_cnt_q + 32'h1;
			if (s_sd_q[1] == shutdown_request_out)
				sd_cnt_q <= 32'h0;
			else if (sd_cnt_q >= filter_cycles(seq_q[2:0])) // [RULE_23]
			begin
				shutdown_request_out <= s_sd_q[1]; // [RULE_01]
				sd_cnt_q <= 32'h0;
			end
			else
				sd_cnt_q <= sd_cnt_q + 32'h1;
		end
	end
	// interval of 4.0 us halved per code step
	tick_counter ramp_timer (
		.clk_in(clk_in),
		.rst_n_in(rst_n),
		.clear_in(!ramp_active_in),
		.limit_in((32'd16 >> seq_q[6:5]) * `US_QTR_CYCLES), // [RULE_02]
		.hit_out(ramp_hit)
	);
	always @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ramp_step_out <= 1'b0;
			prev_reset_q <= 1'b0;
			prev_sleep_q <= 1'b0;
			boot_wait_q <= 1'b0;
			default_supply_apply_out <= 1'b0;
			config_reload_out <= 1'b0;
			seq_start_out <= 1'b0;
			pulsed_lowpower_arm_out <= 1'b0;
			clock_only_off_out <= 1'b0;
			timeout_scale_out <= 3'h0;
			timeout_mult_out <= 7'h00;
			watchdog_kick_out <= 1'b0;
			keepalive_out <= 1'b0;
			motor_stop_out <= 1'b0;
			osc_enable_out <= 1'b0;
			wake_request_out <= 1'b0;
			shutdown_cmd_out <= 1'b0;
		end
		else
		begin
			ramp_step_out <= ramp_hit; // [RULE_02]
			prev_reset_q <= in_reset_mode_in;
			prev_sleep_q <= in_sleep_state_in;
			default_supply_apply_out <= enter_slot0_in &&
				seq_q[`BIT_DEFAULT_SUPPLY_APPLY]; // [RULE_03]
			config_reload_out <= prev_sleep_q && !in_sleep_state_in &&
				seq_q[`BIT_RELOAD]; // [RULE_04]
			if (prev_reset_q && !in_reset_mode_in)
				boot_wait_q <= 1'b1;
			else if (seq_start_out)
				boot_wait_q <= 1'b0;
			seq_start_out <= boot_wait_q && !seq_start_out &&
				(seq_q[`BIT_AUTO_BOOT] || wake_valid_in); // [RULE_05]
			if (in_reset_mode_in && !prev_reset_q)
				pulsed_lowpower_arm_out <= pin_q[`BIT_ECO]; // [RULE_14]
			else if (!in_reset_mode_in)
				pulsed_lowpower_arm_out <= 1'b0;
			if ((in_reset_mode_in && supply_fault_in &&
				pin_q[`BIT_FAULT_CO]) ||
				(in_sleep_state_in && pin_q[`BIT_PD_CO]))
				clock_only_off_out <= 1'b1; // [RULE_16] [RULE_17]
			else if (!in_reset_mode_in && !in_sleep_state_in)
				clock_only_off_out <= 1'b0;
			timeout_scale_out <= flash_q[2:0];
			timeout_mult_out <= (flash_q[2:0] == 3'h0) ? 7'h00 :
				(7'h01 << (flash_q[2:0] - 3'h1)); // [RULE_09]
			watchdog_kick_out <= cmd_q[`BIT_KICK] ||
				(pin_q[`BIT_FB2] && s_fb2_q[1]); // [RULE_20] [RULE_12]
			keepalive_out <= pin_q[`BIT_FB2] && s_fb2_q[1]; // [RULE_12]
			motor_stop_out <= pin_q[`BIT_FB3] && !s_fb3_q[1]; // [RULE_11]
			osc_enable_out <= pin_q[`BIT_CLK_EN]; // [RULE_15]
			wake_request_out <= cmd_q[`BIT_WAKE] &&
				in_sleep_state_in; // [RULE_18]
			shutdown_cmd_out <= cmd_q[`BIT_SHUTDOWN]; // [RULE_19]
		end
	end
	assign fb3_pin_out = s_ck_q[1]; // [RULE_11]
	assign fb3_pin_oe_out = !pin_q[`BIT_FB3]; // [RULE_11]
	assign fb2_pin_out = s_good_q[1]; // [RULE_12]
	assign fb2_pin_oe_out = !pin_q[`BIT_FB2]; // [RULE_12]
	assign fb1_pin_out = pin_q[`BIT_FB1] ? !(seq_busy_in || ramp_busy_in) :
		s_wev_q[1]; // [RULE_13]
	assign fb1_pin_oe_out = 1'b1;
	// flashing; period counter restarts when its limit changes
	reg [31:0] on_lim, per_lim;
	reg flash_en, tflash_on, on_now, ss_prev_q;
	always @*
	begin
		case (flash_q[7:6])
			2'h0: on_lim = `MS_CYCLES * 10;
			2'h1: on_lim = `MS_CYCLES * 20;
			2'h2: on_lim = `MS_CYCLES * 40;
			default: on_lim = `MS_CYCLES * 20;
		endcase // [RULE_06]
		case (flash_q[5:3])
			3'h1: per_lim = `MS_CYCLES * 1000;
			3'h2, 3'h5: per_lim = `MS_CYCLES * 2000;
			3'h3, 3'h6: per_lim = `MS_CYCLES * 4000;
			default: per_lim = `MS_CYCLES * 180;
		endcase // [RULE_07]
		tflash_on = tflash_cnt_q != 32'h0;
		if (flash_q[5:3] == 3'h0)
			flash_en = 1'b0; // [RULE_07]
		else if (flash_q[5:3] >= 3'h5)
			flash_en = s_ss_q[1]; // [RULE_07]
		else
			flash_en = s_chg_q[1] || tflash_on; // [RULE_08] [RULE_21]
		if (flash_q[7:6] == 2'h3)
			on_now = flash_cnt_q < on_lim ||
				(flash_cnt_q >= 2 * on_lim && flash_cnt_q < 3 * on_lim);
		else
			on_now = flash_cnt_q < on_lim; // [RULE_06]
	end
	always @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			flash_cnt_q <= 32'h0;
			flash_lim_q <= 32'h0;
			tflash_cnt_q <= 32'h0;
			ss_prev_q <= 1'b0;
			indicator_out_a_out <= 1'b0;
			indicator_out_b_out <= 1'b0;
		end
		else
		begin
			flash_lim_q <= per_lim;
			if (!flash_en || flash_lim_q != per_lim ||
				flash_cnt_q + 32'h1 >= per_lim)
				flash_cnt_q <= 32'h0;
			else
				flash_cnt_q <= flash_cnt_q + 32'h1;
			ss_prev_q <= s_ss_q[1];
			// fresh detection only, so the flash stays time-limited
			if (timed_flash_enable_in && s_ss_q[1] && !ss_prev_q &&
				!s_chg_q[1])
				tflash_cnt_q <= TIMED_FLASH_CYCLES; // [RULE_21]
			else if (tflash_on && !s_chg_q[1])
				tflash_cnt_q <= tflash_cnt_q - 32'h1;
			else if (s_chg_q[1])
				tflash_cnt_q <= 32'h0;
			indicator_out_a_out <= flash_en && on_now;
			indicator_out_b_out <= flash_en && on_now;
		end
	end
endmodule // sys_control_regs

/* File: hw/sysctl_defs.vh */
`ifndef SYSCTL_DEFS_VH
`define SYSCTL_DEFS_VH
`define ADDR_SEQ_CFG 9'h010
`define ADDR_FLASH_CFG 9'h011
`define ADDR_PIN_CFG 9'h012
`define ADDR_CMD 9'h013
`define ADDR_LOCK_LO 9'h081
`define ADDR_LOCK_HI 9'h120
`define RST_SEQ_CFG 8'h00
`define RST_FLASH_CFG 8'h00
`define RST_PIN_CFG 8'h04
`define BIT_DEFAULT_SUPPLY_APPLY 7
`define BIT_RELOAD 4
`define BIT_AUTO_BOOT 3
`define BIT_LOCK 7
`define BIT_FB3 6
`define BIT_FB2 5
`define BIT_FB1 4
`define BIT_ECO 3
`define BIT_CLK_EN 2
`define BIT_FAULT_CO 1
`define BIT_PD_CO 0
`define BIT_WAKE 2
`define BIT_SHUTDOWN 1
`define BIT_KICK 0
`define CMD_MASK 8'h07
`define CLK_MHZ 40
`define WAKE_HOLD_S 16
`define MS_CYCLES (`CLK_MHZ * 1000)
`define US_QTR_CYCLES (`CLK_MHZ / 4)
`endif

/* File: hw/tick_counter.v */
`timescale 1ns/1ps
module tick_counter (
	input wire clk_in,
	input wire rst_n_in,
	input wire clear_in,
	input wire [31:0] limit_in,
	output reg hit_out
);
	reg [31:0] cnt_q;
	always @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			cnt_q <= 32'h0;
			hit_out <= 1'b0;
		end
		else if (clear_in || cnt_q + 32'h1 >= limit_in)
		begin
			cnt_q <= 32'h0;
			hit_out <= !clear_in;
		end
		else
		begin
			cnt_q <= cnt_q + 32'h1;
			hit_out <= 1'b0;
		end
	end
endmodule // tick_counter

/* File: verif/sys_control_regs_tb_top.sv */
`timescale 1ns/1ps
`include "sysctl_defs.vh"
module sys_control_regs_tb_top;
	reg clk_in = 1'b0;
	reg nrst_in = 1'b0;
	reg [8:0] addr_in = 9'h000;
	reg [7:0] wdata_in = 8'h00;
	reg wr_in = 1'b0, rd_in = 1'b0, in_reset_mode_in = 1'b0;
	reg in_sleep_state_in = 1'b0, in_active_mode_in = 1'b0;
	reg monitor_on_in = 1'b0, ramp_active_in = 1'b0;
	reg power_key_input_in = 1'b1, shutdown_request_input_in = 1'b1;
	reg [15:0] cnt_q = 16'h0000;
	wire enter_slot0_in, supply_fault_in, wake_valid_in, seq_busy_in;
	wire timed_flash_enable_in, start_supply_in, charger_present_input_in;
	wire supplies_good_in, wake_event_indicator_in, clk32k_in, fb2_pin_in;
	wire fb3_pin_in, ramp_busy_in, locked_wr_out, power_key_out;
	wire ramp_step_out, pulsed_lowpower_arm_out, clock_only_off_out;
	wire watchdog_kick_out, osc_enable_out, wake_request_out;
	wire shutdown_cmd_out, shutdown_request_out, fb2_pin_oe_out;
	wire fb3_pin_oe_out;
	wire [7:0] rdata_out;
	wire [2:0] timeout_scale_out;
	wire [6:0] timeout_mult_out;
	integer bad_count = 0;
	integer checks = 0;
	integer i, k;
	// free-running pattern keeps the pin and status inputs moving
	assign {enter_slot0_in, supply_fault_in, wake_valid_in, seq_busy_in,
		timed_flash_enable_in, start_supply_in, charger_present_input_in,
		supplies_good_in, wake_event_indicator_in, fb2_pin_in, fb3_pin_in,
		clk32k_in} = cnt_q[15:4];
	assign ramp_busy_in = ramp_active_in;
	always #12.5 clk_in = ~clk_in;
	always @(posedge clk_in)
		cnt_q <= cnt_q + 16'h0001;
	sys_control_regs #(.WAKE_HOLD_CYCLES(100), .TIMED_FLASH_CYCLES(200))
		sys_control_regs_inst (.*,
		.default_supply_apply_out(), .config_reload_out(), .seq_start_out(),
		.indicator_out_a_out(), .indicator_out_b_out(), .keepalive_out(),
		.motor_stop_out(), .fb1_pin_out(), .fb1_pin_oe_out(),
		.fb2_pin_out(), .fb3_pin_out());
	task check(input logic [31:0] seen, input logic [31:0] exp, input string n);
		checks = checks + 1;
		if (seen !== exp)
		begin
			bad_count = bad_count + 1;
			$display("unexpected %s: expected %h seen %h", n, exp, seen);
		end
	endtask
	task tick(input integer n);
		repeat (n) @(posedge clk_in);
	endtask
	task wr(input logic [8:0] a, input logic [7:0] d);
		@(posedge clk_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask
	task rdc(input logic [8:0] a, input logic [7:0] e, input string n);
		@(posedge clk_in);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1 check(rdata_out, e, n);
	endtask
	// flag is combinational, so look inside the write cycle
	task lk(input logic [8:0] a, input logic e);
		@(posedge clk_in);
		wr_in <= 1'b1;
		addr_in <= a;
		#1 check(locked_wr_out, e, "lock flag");
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask
	// window is a multiple of every interval, so phase does not matter
	task steps(input logic [1:0] c);
		k = 0;
		wr(`ADDR_SEQ_CFG, {1'b0, c, 5'h00});
		tick(200);
		repeat (640)
		begin
			@(posedge clk_in);
			#1 k = k + (ramp_step_out === 1'b1);
		end
		check(k, 32'd4 << c, "ramp steps");
	endtask
	task print_verdict;
		if (bad_count == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		#2000000;
		bad_count = bad_count + 1;
		print_verdict;
	end
	initial
	begin
		tick(16);
		nrst_in <= 1'b1;
		tick(3);
		rdc(`ADDR_SEQ_CFG, `RST_SEQ_CFG, "seq cfg");
		rdc(`ADDR_FLASH_CFG, `RST_FLASH_CFG, "flash cfg");
		rdc(`ADDR_PIN_CFG, `RST_PIN_CFG, "pin cfg");
		rdc(`ADDR_CMD, 8'h00, "cmd");
		rdc(9'h020, 8'h00, "unmapped");
		wr(`ADDR_SEQ_CFG, 8'hA5);
		rdc(`ADDR_SEQ_CFG, 8'hA5, "seq cfg");
		// debounce: a short dip is filtered, a long one gets through
		wr(`ADDR_SEQ_CFG, 8'h01);
		power_key_input_in <= 1'b0;
		tick(2000);
		power_key_input_in <= 1'b1;
		#1 check(power_key_out, 1'b1, "key filtered");
		tick(10);
		power_key_input_in <= 1'b0;
		shutdown_request_input_in <= 1'b0;
		tick(4100);
		#1 check(power_key_out, 1'b0, "key passed");
		check(shutdown_request_out, 1'b0, "shutdown passed");
		@(posedge clk_in);
		ramp_active_in <= 1'b1;
		for (i = 0; i < 4; i = i + 1)
			steps(i[1:0]);
		ramp_active_in <= 1'b0;
		for (i = 0; i < 8; i = i + 1)
		begin
			wr(`ADDR_FLASH_CFG, i[7:0]);
			tick(2);
			#1 check(timeout_mult_out, i == 0 ? 0 : 1 << (i - 1), "mult");
			check(timeout_scale_out, i, "scale");
		end
		wr(`ADDR_PIN_CFG, 8'h84);
		rdc(`ADDR_PIN_CFG, 8'h84, "pin cfg");
		lk(9'h081, 1'b1);
		lk(9'h120, 1'b1);
		lk(9'h080, 1'b0);
		lk(9'h121, 1'b0);
		wr(`ADDR_PIN_CFG, 8'h74);
		#1 check(fb3_pin_oe_out, 1'b0, "fb3 oe");
		check(fb2_pin_oe_out, 1'b0, "fb2 oe");
		wr(`ADDR_PIN_CFG, 8'h04);
		#1 check(fb3_pin_oe_out, 1'b1, "fb3 oe");
		check(fb2_pin_oe_out, 1'b1, "fb2 oe");
		lk(9'h0A0, 1'b0);
		monitor_on_in <= 1'b1;
		tick(2);
		wr(`ADDR_PIN_CFG, 8'h00);
		rdc(`ADDR_PIN_CFG, 8'h04, "clock enable");
		check(osc_enable_out, 1'b1, "osc enable");
		wr(`ADDR_CMD, 8'hF8);
		rdc(`ADDR_CMD, 8'h00, "reserved");
		wr(`ADDR_CMD, 8'h01);
		k = 0;
		repeat (6)
		begin
			@(posedge clk_in);
			#1 k = k + (watchdog_kick_out === 1'b1);
		end
		check(k, 1, "kick count");
		rdc(`ADDR_CMD, 8'h00, "kick bit");
		wr(`ADDR_PIN_CFG, 8'h0D);
		wr(`ADDR_CMD, 8'h02);
		tick(2);
		in_reset_mode_in <= 1'b1;
		#1 check(shutdown_cmd_out, 1'b1, "shutdown set");
		tick(5);
		#1 check(shutdown_cmd_out, 1'b0, "shutdown clr");
		check(pulsed_lowpower_arm_out, 1'b1, "eco arm");
		rdc(`ADDR_CMD, 8'h00, "shutdown bit");
		@(posedge clk_in);
		in_reset_mode_in <= 1'b0;
		in_sleep_state_in <= 1'b1;
		tick(5);
		#1 check(clock_only_off_out, 1'b1, "clock only");
		wr(`ADDR_CMD, 8'h04);
		tick(2);
		#1 check(wake_request_out, 1'b1, "wake request");
		@(posedge clk_in);
		in_sleep_state_in <= 1'b0;
		in_active_mode_in <= 1'b1;
		tick(50);
		rdc(`ADDR_CMD, 8'h04, "wake held");
		check(clock_only_off_out, 1'b0, "clock only clr");
		tick(60);
		rdc(`ADDR_CMD, 8'h00, "wake clr");
		print_verdict;
	end
endmodule // sys_control_regs_tb_top

/* File: verif/sysctl_chk.sv */
`timescale 1ns/1ps
module sysctl_chk (
	input wire clk_in,
	input wire nrst_in,
	input wire [8:0] addr_in,
	input wire [7:0] wdata_in,
	input wire wr_in,
	input wire rd_in,
	input wire [7:0] rdata_out,
	input wire locked_wr_out,
	input wire in_reset_mode_in,
	input wire in_active_mode_in,
	input wire in_sleep_state_in,
	input wire monitor_on_in,
	input wire keepalive_out,
	input wire motor_stop_out,
	input wire fb2_pin_oe_out,
	input wire fb3_pin_oe_out,
	input wire watchdog_kick_out,
	input wire osc_enable_out,
	input wire wake_request_out,
	input wire shutdown_cmd_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!nrst_in);
	wire cmd_wr = wr_in && addr_in == 9'h013;
	cmd_reserved_a:
		assert property (rd_in && addr_in == 9'h013 |=> rdata_out[7:3] == 5'h00)
		else $error("command reserved bits read nonzero");
	read_idle_a:
		assert property (rd_in ##1 !rd_in |=> rdata_out == 8'h00)
		else $error("read data stood too long");
	lock_range_a:
		assert property (locked_wr_out |-> wr_in && addr_in >= 9'h081
			&& addr_in <= 9'h120)
		else $error("lock flagged outside range");
	lock_edges_a:
		assert property (wr_in && (addr_in == 9'h080 || addr_in == 9'h121)
			|-> !locked_wr_out)
		else $error("lock flagged at range edge");
	kick_pulse_a:
		assert property (cmd_wr && wdata_in[0] |-> ##[1:3] watchdog_kick_out)
		else $error("kick write gave no kick");
	shut_set_a:
		assert property (cmd_wr && wdata_in[1] && !in_reset_mode_in
			|-> ##[1:2] shutdown_cmd_out)
		else $error("shutdown write not seen");
	shut_clear_a:
		assert property ((in_reset_mode_in && !cmd_wr)[*4] |-> !shutdown_cmd_out)
		else $error("shutdown held in reset mode");
	wake_set_a:
		assert property (cmd_wr && wdata_in[2] && in_sleep_state_in ##1
			in_sleep_state_in |=> wake_request_out)
		else $error("wake write not seen");
	wake_hold_a:
		assert property ((wake_request_out && in_sleep_state_in &&
			!in_active_mode_in)[*3] |=> wake_request_out)
		else $error("wake cleared outside active mode");
	keep_gate_a:
		assert property ($past(fb2_pin_oe_out) |-> !keepalive_out)
		else $error("keepalive seen in output mode");
	motor_gate_a:
		assert property ($past(fb3_pin_oe_out) |-> !motor_stop_out)
		else $error("motor stop seen in output mode");
	osc_locked_a:
		assert property ($past(monitor_on_in, 2) |-> $stable(osc_enable_out))
		else $error("oscillator enable moved after monitor");
	cover property (cmd_wr && wdata_in[0] ##2 watchdog_kick_out);
	cover property (shutdown_cmd_out ##1 in_reset_mode_in [*4]);
	cover property (locked_wr_out);
endmodule // sysctl_chk
bind sys_control_regs sysctl_chk sysctl_chk_inst (.clk_in, .nrst_in,
	.addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .locked_wr_out,
	.in_reset_mode_in, .in_active_mode_in, .in_sleep_state_in,
	.monitor_on_in, .keepalive_out, .motor_stop_out, .fb2_pin_oe_out,
	.fb3_pin_oe_out,
	.watchdog_kick_out, .osc_enable_out, .wake_request_out,
	.shutdown_cmd_out);
